// [hw/cpc_pkg.sv]
// Package: register map, reset values, field positions and timing constants
package cpc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CPC_ADDR_TEMP_ZONE = 8'h1F;
  localparam logic [7:0] CPC_ADDR_OCP_CFG   = 8'h20;
  localparam logic [7:0] CPC_ADDR_CTL_CFG   = 8'h21;

  localparam logic [7:0] CPC_RST_TEMP_ZONE  = 8'h05;
  localparam logic [7:0] CPC_RST_OCP_CFG    = 8'h0D;
  localparam logic [7:0] CPC_RST_CTL_CFG    = 8'h00;
  localparam logic [7:0] CPC_MASK_CTL_CFG   = 8'hFB;  // Bit 2 is unimplemented

  // ==========================================================================
  // Field positions
  localparam int CPC_TEMP_PROFILE_ENABLE   = 7;
  localparam int CPC_TERM_VOLTAGE_BACKOFF  = 6;
  localparam int CPC_COOL_VOLTAGE_REDUCE   = 5;
  localparam int CPC_WARM_CURRENT_HALVE    = 4;
  localparam int CPC_RESERVED_BIT          = 3;
  localparam int CPC_SETPOINT_MSB          = 2;
  localparam int CPC_OC_DEBOUNCE_SELECT    = 7;
  localparam int CPC_OC_ALARM_ONLY         = 6;
  localparam int CPC_OC_MONITOR_MODE       = 5;
  localparam int CPC_OC_RECYCLE_SELECT     = 4;
  localparam int CPC_OC_THRESHOLD_MSB      = 3;
  localparam int CPC_WD_SWITCH_OFF_SCOPE   = 7;
  localparam int CPC_FACTORY_BOOST_PERMIT  = 6;
  localparam int CPC_SWITCH_FORCE_OFF      = 5;

  // ==========================================================================
  // Analog scaling
  localparam logic [7:0] CPC_SETPOINT_BASE_DEGC = 8'h56;  // 86 degC
  localparam logic [7:0] CPC_SETPOINT_STEP_DEGC = 8'h06;  // 6 degC per code
  localparam int         CPC_CV_STEP_MV         = 10;     // Termination voltage code step
  localparam int         CPC_BACKOFF_SMALL_MV   = 100;
  localparam int         CPC_BACKOFF_LARGE_MV   = 150;
  localparam logic [7:0] CPC_BACKOFF_SMALL_CODE = 8'(CPC_BACKOFF_SMALL_MV / CPC_CV_STEP_MV);
  localparam logic [7:0] CPC_BACKOFF_LARGE_CODE = 8'(CPC_BACKOFF_LARGE_MV / CPC_CV_STEP_MV);
  localparam logic [3:0] CPC_MODE_BOOST         = 4'h9;   // Operating-mode code for boost
  localparam logic [3:0] CPC_MODE_RESET         = 4'h0;

  // ==========================================================================
  // Timing
  localparam int CPC_TMR_W             = 24;
  localparam int CPC_CLK_PERIOD_NS     = 100;
  localparam int CPC_DEB_SHORT_NS      = 105000;
  localparam int CPC_DEB_LONG_NS       = 10000000;
  localparam int CPC_RECOVER_NS        = 150000000;
  localparam int CPC_DEB_SHORT_CYC     = (CPC_DEB_SHORT_NS + CPC_CLK_PERIOD_NS - 1) / CPC_CLK_PERIOD_NS;
  localparam int CPC_DEB_LONG_CYC      = (CPC_DEB_LONG_NS + CPC_CLK_PERIOD_NS - 1) / CPC_CLK_PERIOD_NS;
  localparam int CPC_RECOVER_CYC       = (CPC_RECOVER_NS + CPC_CLK_PERIOD_NS - 1) / CPC_CLK_PERIOD_NS;

  // ==========================================================================
  // Battery switch sequencer states
  typedef enum logic [4:0] {
    CPC_SW_CLOSED   = 5'b00001,
    CPC_SW_DEBOUNCE = 5'b00010,
    CPC_SW_ALARM    = 5'b00100,
    CPC_SW_OFF      = 5'b01000,
    CPC_SW_WAIT_CHG = 5'b10000
  } cpc_sw_state_t;

endpackage

// [hw/cpc_timer_if.sv]
// Interface: start, load value and expiry pulse between sequencer and timer
`timescale 1ns/1ps
interface cpc_timer_if;
  import cpc_pkg::*;
  logic                 start;
  logic [CPC_TMR_W-1:0] load;
  logic                 done;
  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface

// [hw/cpc_sync3.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module cpc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import cpc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } cpc_sync_state_t;

  cpc_sync_state_t st_reg;
  cpc_sync_state_t st_next;

  // Shift chain; only the agreeing bits update the output
  always_comb begin
    st_next     = st_reg;
    st_next.s1  = din;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.out = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.out & (st_reg.s2 ^ st_reg.s3));
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.out;
endmodule

// [hw/cpc_timer.sv]
// Down-counter that pulses done once the loaded number of cycles has elapsed
`timescale 1ns/1ps
module cpc_timer (
  input  wire logic clk_sys,
  input  wire logic rst,
  cpc_timer_if.tmr  tif
);
  import cpc_pkg::*;

  typedef struct packed {
    logic [CPC_TMR_W-1:0] cnt;
    logic                 done;
  } cpc_tmr_state_t;

  cpc_tmr_state_t st_reg;
  cpc_tmr_state_t st_next;

  // A start reloads at any time; done pulses on the last count
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (tif.start) begin
      st_next.cnt = tif.load;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - 1'b1;
      st_next.done = (st_reg.cnt == {{(CPC_TMR_W-1){1'b0}}, 1'b1});
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.done = st_reg.done;
endmodule

// [hw/cpc_top.sv]
// Charger protection configuration registers and the logic they steer
`timescale 1ns/1ps

// Operation
// (RULE1) Profile enable gates temperature-zone adjustments
// (RULE2) Back-off bit picks 100 or 150 mV
// (RULE3) Cool zone lowers termination voltage by back-off
// (RULE4) Warm zone halves fast-charge current
// (RULE5) Setpoint 86 to 128 degC, flag above
// (RULE6) Debounce select picks 105 us or 10 ms
// (RULE7) Trip interrupts, switch opens after delay
// (RULE8) Alarm-only trip interrupts, switch stays closed
// (RULE9) Monitor bit selects automatic or continuous supervision
// (RULE10) Recycle 0: recover after 150 ms with charger
// (RULE11) Recycle 1: recover after 150 ms always
// (RULE12) Threshold code zero disables overcurrent protection
// (RULE13) Watchdog scope: charger only, or all 150 ms
// (RULE14) Disconnect high, permit 0: ignore mode changes
// (RULE15) Disconnect high, permit 1: allow boost mode
// (RULE16) Reserved bit inert, reads back last write
module cpc_top #(
  parameter int DEB_LONG_CYC = cpc_pkg::CPC_DEB_LONG_CYC,
  parameter int RECOVER_CYC  = cpc_pkg::CPC_RECOVER_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       zone_cool_pin,
  input  wire logic       zone_warm_pin,
  input  wire logic       overcurrent_pin,
  input  wire logic       charger_valid_pin,
  input  wire logic       battery_disconnect_input,
  input  wire logic [7:0] term_voltage_setting,
  input  wire logic [7:0] fast_charge_current_setting,
  input  wire logic [7:0] junction_temp_degc,
  input  wire logic       watchdog_expired,
  input  wire logic       mode_req,
  input  wire logic [3:0] mode_code,
  output logic      [7:0] term_voltage_target,
  output logic      [7:0] fast_charge_current_target,
  output logic      [7:0] junction_setpoint_degc,
  output logic            thermal_regulation_flag,
  output logic      [3:0] overcurrent_threshold,
  output logic            overcurrent_monitor_continuous,
  output logic            overcurrent_irq,
  output logic            battery_switch_on,
  output logic            buck_enable,
  output logic            charger_enable,
  output logic      [3:0] operating_mode
);
  import cpc_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]           r_temp;
    logic [7:0]           r_ocp;
    logic [7:0]           r_ctl;
    logic [7:0]           rdata;
    logic                 rvalid;
    cpc_sw_state_t        sw;
    logic                 recover_any;
    logic                 wd_chg_off;
    logic                 irq;
    logic                 sw_on;
    logic                 chg_en;
    logic [7:0]           cv;
    logic [7:0]           cc;
    logic [7:0]           setpoint;
    logic                 treg;
    logic [3:0]           mode;
    logic                 tmr_start;
    logic [CPC_TMR_W-1:0] tmr_load;
  } cpc_top_state_t;

  cpc_top_state_t st_reg;
  cpc_top_state_t st_next;
  logic [3:0]     pins_sync;
  logic           zone_cool;
  logic           zone_warm;
  logic           oc_level;
  logic           chg_ok;
  logic           disc_sync;
  logic           trip;
  logic           force_off;
  logic           wd_hit;

  cpc_timer_if tif ();

  // Setpoint decode shared by the compare and the setpoint output
  function automatic logic [7:0] cpc_setpoint(input logic [2:0] code);
    cpc_setpoint = CPC_SETPOINT_BASE_DEGC + 8'(CPC_SETPOINT_STEP_DEGC * code);
  endfunction

  // ==========================================================================
  // Pin synchronisers and timer
  cpc_sync3 #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({zone_cool_pin, zone_warm_pin, overcurrent_pin, charger_valid_pin}),
    .dout    (pins_sync)
  );

  cpc_sync3 #(.W(1)) u_sync_disc (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (battery_disconnect_input),
    .dout    (disc_sync)
  );

  cpc_timer u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tif     (tif.tmr)
  );

  assign zone_cool = pins_sync[3];
  assign zone_warm = pins_sync[2];
  assign oc_level  = pins_sync[1];
  assign chg_ok    = pins_sync[0];
  assign trip      = oc_level && (st_reg.r_ocp[CPC_OC_THRESHOLD_MSB:0] != 4'h0);  // [RULE12]
  assign force_off = st_reg.r_ctl[CPC_SWITCH_FORCE_OFF];
  assign wd_hit    = watchdog_expired && st_reg.r_ctl[CPC_WD_SWITCH_OFF_SCOPE];
  assign tif.start = st_reg.tmr_start;
  assign tif.load  = st_reg.tmr_load;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic       wr_hit;
    logic [7:0] backoff;
    wr_hit            = 1'b0;
    backoff           = 8'h00;
    st_next           = st_reg;
    st_next.rvalid    = reg_rd;
    st_next.irq       = 1'b0;
    st_next.tmr_start = 1'b0;

    // Register writes; the reserved bit is stored but steers nothing
    if (reg_wr) begin
      unique case (reg_addr)
        CPC_ADDR_TEMP_ZONE: begin
          st_next.r_temp = reg_wdata;  // [RULE16]
          wr_hit = 1'b1;
        end
        CPC_ADDR_OCP_CFG: begin
          st_next.r_ocp = reg_wdata;
          wr_hit = 1'b1;
        end
        CPC_ADDR_CTL_CFG: begin
          st_next.r_ctl = reg_wdata & CPC_MASK_CTL_CFG;
          wr_hit = 1'b1;
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end

    // Register reads; unmapped addresses read zero
    if (reg_rd) begin
      unique case (reg_addr)
        CPC_ADDR_TEMP_ZONE: st_next.rdata = st_reg.r_temp;
        CPC_ADDR_OCP_CFG:   st_next.rdata = st_reg.r_ocp;
        CPC_ADDR_CTL_CFG:   st_next.rdata = st_reg.r_ctl;
        default:            st_next.rdata = 8'h00;
      endcase
    end

    // Temperature-zone targets
    backoff = st_reg.r_temp[CPC_TERM_VOLTAGE_BACKOFF] ? CPC_BACKOFF_LARGE_CODE : CPC_BACKOFF_SMALL_CODE;  // [RULE2]
    st_next.cv = term_voltage_setting;
    st_next.cc = fast_charge_current_setting;
    if (st_reg.r_temp[CPC_TEMP_PROFILE_ENABLE]) begin  // [RULE1]
      if (zone_cool && st_reg.r_temp[CPC_COOL_VOLTAGE_REDUCE]) begin  // [RULE3]
        st_next.cv = (term_voltage_setting > backoff) ? term_voltage_setting - backoff : 8'h00;
      end
      if (zone_warm && st_reg.r_temp[CPC_WARM_CURRENT_HALVE]) begin  // [RULE4]
        st_next.cc = {1'b0, fast_charge_current_setting[7:1]};
      end
    end

    // Junction regulation compare
    st_next.setpoint = cpc_setpoint(st_reg.r_temp[CPC_SETPOINT_MSB:0]);  // [RULE5]
    st_next.treg     = junction_temp_degc > cpc_setpoint(st_reg.r_temp[CPC_SETPOINT_MSB:0]);  // [RULE5]

    // Watchdog charger-only shutdown; set wins over the clearing write
    if (watchdog_expired && !st_reg.r_ctl[CPC_WD_SWITCH_OFF_SCOPE]) begin
      st_next.wd_chg_off = 1'b1;  // [RULE13]
    end else if (wr_hit) begin
      st_next.wd_chg_off = 1'b0;
    end

    // Battery switch sequencer
    unique case (st_reg.sw)
      CPC_SW_CLOSED, CPC_SW_DEBOUNCE, CPC_SW_ALARM: begin
        if (wd_hit || force_off) begin
          st_next.sw          = CPC_SW_OFF;  // [RULE13]
          st_next.tmr_start   = 1'b1;
          st_next.tmr_load    = CPC_TMR_W'(RECOVER_CYC);
          st_next.recover_any = wd_hit || st_reg.r_ocp[CPC_OC_RECYCLE_SELECT];  // [RULE11]
        end else if (!trip) begin
          st_next.sw = CPC_SW_CLOSED;
        end else if (st_reg.sw == CPC_SW_CLOSED) begin
          st_next.sw        = CPC_SW_DEBOUNCE;
          st_next.irq       = 1'b1;  // [RULE7] [RULE8]
          st_next.tmr_start = 1'b1;
          st_next.tmr_load  = st_reg.r_ocp[CPC_OC_DEBOUNCE_SELECT] ? CPC_TMR_W'(DEB_LONG_CYC)
                                                                   : CPC_TMR_W'(CPC_DEB_SHORT_CYC);  // [RULE6]
        end else if (st_reg.sw == CPC_SW_DEBOUNCE && tif.done) begin
          if (st_reg.r_ocp[CPC_OC_ALARM_ONLY]) begin
            st_next.sw = CPC_SW_ALARM;  // [RULE8]
          end else begin
            st_next.sw          = CPC_SW_OFF;  // [RULE7]
            st_next.tmr_start   = 1'b1;
            st_next.tmr_load    = CPC_TMR_W'(RECOVER_CYC);
            st_next.recover_any = st_reg.r_ocp[CPC_OC_RECYCLE_SELECT];  // [RULE10] [RULE11]
          end
        end
      end
      CPC_SW_OFF: begin
        if (force_off || wd_hit) begin
          st_next.tmr_start = 1'b1;  // Hold time restarts while still forced
          st_next.tmr_load  = CPC_TMR_W'(RECOVER_CYC);
        end else if (tif.done) begin
          st_next.sw = (st_reg.recover_any || chg_ok) ? CPC_SW_CLOSED : CPC_SW_WAIT_CHG;  // [RULE10] [RULE11]
        end
      end
      CPC_SW_WAIT_CHG: begin
        if (force_off || wd_hit) begin
          st_next.sw        = CPC_SW_OFF;
          st_next.tmr_start = 1'b1;
          st_next.tmr_load  = CPC_TMR_W'(RECOVER_CYC);
        end else if (chg_ok) begin
          st_next.sw = CPC_SW_CLOSED;  // [RULE10]
        end
      end
      default: begin
        st_next.sw = CPC_SW_OFF;
      end
    endcase
    st_next.sw_on  = st_next.sw inside {CPC_SW_CLOSED, CPC_SW_DEBOUNCE, CPC_SW_ALARM};
    st_next.chg_en = st_next.sw_on && !st_next.wd_chg_off;

    // Operating-mode requests under battery disconnect
    if (mode_req) begin
      if (!disc_sync) begin
        st_next.mode = mode_code;
      end else if (st_reg.r_ctl[CPC_FACTORY_BOOST_PERMIT] && mode_code == CPC_MODE_BOOST) begin
        st_next.mode = mode_code;  // [RULE15]
      end else begin
        st_next.mode = st_reg.mode;  // [RULE14]
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg             <= '0;
      st_reg.r_temp      <= CPC_RST_TEMP_ZONE;
      st_reg.r_ocp       <= CPC_RST_OCP_CFG;
      st_reg.r_ctl       <= CPC_RST_CTL_CFG;
      st_reg.sw          <= CPC_SW_CLOSED;
      st_reg.sw_on       <= 1'b1;
      st_reg.chg_en      <= 1'b1;
      st_reg.mode        <= CPC_MODE_RESET;
      st_reg.setpoint    <= CPC_SETPOINT_BASE_DEGC;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata                      = st_reg.rdata;
  assign reg_rvalid                     = st_reg.rvalid;
  assign term_voltage_target            = st_reg.cv;
  assign fast_charge_current_target     = st_reg.cc;
  assign junction_setpoint_degc         = st_reg.setpoint;
  assign thermal_regulation_flag        = st_reg.treg;
  assign overcurrent_threshold          = st_reg.r_ocp[CPC_OC_THRESHOLD_MSB:0];
  assign overcurrent_monitor_continuous = st_reg.r_ocp[CPC_OC_MONITOR_MODE];  // [RULE9]
  assign overcurrent_irq                = st_reg.irq;
  assign battery_switch_on              = st_reg.sw_on;
  assign buck_enable                    = st_reg.sw_on;
  assign charger_enable                 = st_reg.chg_en;
  assign operating_mode                 = st_reg.mode;

  // ==========================================================================
  // Assertions
  AST_PROFILE_OFF: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE1]
    !st_reg.r_temp[CPC_TEMP_PROFILE_ENABLE] |=> term_voltage_target == $past(term_voltage_setting)
      && fast_charge_current_target == $past(fast_charge_current_setting))
    else $error("targets changed with profile disabled");

  AST_COOL_BACKOFF: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE3]
    st_reg.r_temp[7] && st_reg.r_temp[5] && zone_cool && term_voltage_setting > 8'h0F
      |=> term_voltage_target == $past(term_voltage_setting) - ($past(st_reg.r_temp[6]) ? 8'h0F : 8'h0A))
    else $error("cool zone back-off wrong");

  AST_WARM_HALF: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE4]
    st_reg.r_temp[7] && st_reg.r_temp[4] && zone_warm
      |=> fast_charge_current_target == {1'b0, $past(fast_charge_current_setting[7:1])})
    else $error("warm zone current not halved");

  AST_TREG: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE5]
    ##1 thermal_regulation_flag == ($past(junction_temp_degc) > 8'(8'd86 + 8'd6 * $past(st_reg.r_temp[2:0]))))
    else $error("thermal regulation flag wrong");

  AST_DEB_LOAD: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE6]
    st_reg.tmr_start && st_reg.sw == CPC_SW_DEBOUNCE
      |-> st_reg.tmr_load == (st_reg.r_ocp[7] ? CPC_TMR_W'(DEB_LONG_CYC) : CPC_TMR_W'(CPC_DEB_SHORT_CYC)))
    else $error("debounce length wrong");

  AST_IRQ_CLOSED: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE7]
    overcurrent_irq |-> battery_switch_on ##1 !overcurrent_irq)
    else $error("interrupt with switch open or not a pulse");

  AST_ALARM_CLOSED: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE8]
    st_reg.sw == CPC_SW_ALARM |-> battery_switch_on && buck_enable)
    else $error("alarm-only opened the switch");

  AST_WAIT_CHARGER: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE10]
    st_reg.sw == CPC_SW_OFF && tif.done && !force_off && !wd_hit && !st_reg.recover_any && !chg_ok
      |=> !battery_switch_on)
    else $error("recovered without charger");

  AST_THR_ZERO: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE12]
    st_reg.r_ocp[3:0] == 4'h0 |=> !overcurrent_irq)
    else $error("trip with protection disabled");

  AST_WD_CHARGER: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE13]
    watchdog_expired && !st_reg.r_ctl[7] |=> !charger_enable)
    else $error("charger on after watchdog expiry");

  AST_MODE_LOCK: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE14]
    disc_sync && !st_reg.r_ctl[6] |=> $stable(operating_mode))
    else $error("mode changed while locked");

  AST_MODE_BOOST: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE15]
    disc_sync && st_reg.r_ctl[6] && mode_req && mode_code == CPC_MODE_BOOST |=> operating_mode == CPC_MODE_BOOST)
    else $error("boost change refused");

  AST_RESERVED: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE16]
    reg_wr && reg_addr == CPC_ADDR_TEMP_ZONE ##1 !reg_wr ##1 reg_rd && reg_addr == CPC_ADDR_TEMP_ZONE && !reg_wr
      |=> reg_rvalid && reg_rdata[3] == $past(reg_wdata[3], 3))
    else $error("reserved bit readback wrong");

endmodule

// [dv/cpc_host_model.sv]
// Host model: issues register writes and reads on the strobe port
`timescale 1ns/1ps
module cpc_host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write; called on a rising edge, returns two edges later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;  // Released data shows the inverse
    @(posedge clk_sys);
  endtask

  // One read strobe; the bench monitor collects the answer
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// [dv/test_charger_protection_config_regs.sv]
// Testbench: register access, temperature zones, overcurrent, watchdog and mode gating
`timescale 1ns/1ps
module test_charger_protection_config_regs;
  import cpc_pkg::*;
  logic       clk_sys = 1'b0, rst = 1'b1, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, term_voltage_target, fast_charge_current_target;
  logic [7:0] junction_setpoint_degc, tv, cc, cfg;
  logic       zone_cool_pin = 1'b0, zone_warm_pin = 1'b0, overcurrent_pin = 1'b0, charger_valid_pin = 1'b0;
  logic       battery_disconnect_input = 1'b0, watchdog_expired = 1'b0, mode_req = 1'b0;
  logic [7:0] term_voltage_setting = 8'h00, fast_charge_current_setting = 8'h00, junction_temp_degc = 8'h00;
  logic [3:0] mode_code = 4'h0, overcurrent_threshold, operating_mode;
  logic       thermal_regulation_flag, overcurrent_monitor_continuous, overcurrent_irq;
  logic       battery_switch_on, buck_enable, charger_enable;
  logic [7:0] exp_q[$];
  int         mismatches = 0, n_tests = 0, irq_cnt = 0, cycles = 0, k;

  always #50 clk_sys = ~clk_sys;

  cpc_host_model host_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));

  cpc_top #(.DEB_LONG_CYC(50), .RECOVER_CYC(100)) cpc_top_i (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .zone_cool_pin(zone_cool_pin), .zone_warm_pin(zone_warm_pin),
    .overcurrent_pin(overcurrent_pin), .charger_valid_pin(charger_valid_pin),
    .battery_disconnect_input(battery_disconnect_input), .term_voltage_setting(term_voltage_setting),
    .fast_charge_current_setting(fast_charge_current_setting), .junction_temp_degc(junction_temp_degc),
    .watchdog_expired(watchdog_expired), .mode_req(mode_req), .mode_code(mode_code),
    .term_voltage_target(term_voltage_target), .fast_charge_current_target(fast_charge_current_target),
    .junction_setpoint_degc(junction_setpoint_degc), .thermal_regulation_flag(thermal_regulation_flag),
    .overcurrent_threshold(overcurrent_threshold), .overcurrent_monitor_continuous(overcurrent_monitor_continuous),
    .overcurrent_irq(overcurrent_irq), .battery_switch_on(battery_switch_on), .buck_enable(buck_enable),
    .charger_enable(charger_enable), .operating_mode(operating_mode));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    mismatches += exp_q.size();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_i.rd(a);
  endtask

  task automatic wait_sw(input logic v, input int lim);
    int i = 0;
    while (battery_switch_on !== v && i < lim) begin
      tick(1);
      i++;
    end
    check(battery_switch_on, v);
  endtask

  task automatic pulse_wd();
    watchdog_expired <= 1'b1;
    tick(1);
    watchdog_expired <= 1'b0;
    tick(3);
  endtask

  task automatic mode(input logic [3:0] c);
    mode_code <= c;
    mode_req  <= 1'b1;
    tick(1);
    mode_req  <= 1'b0;
    tick(2);
  endtask

  // Read answers are matched against the oldest expectation
  always @(posedge clk_sys) begin
    if (reg_rvalid === 1'b1)
      check(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    if (overcurrent_irq === 1'b1)
      irq_cnt++;
    cycles++;
    if (cycles > 50000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    k = $urandom(32'h5BFFC441);
    tick(3);
    rst <= 1'b0;
    tick(1);
    rd(8'h1F, 8'h05);
    rd(8'h20, 8'h0D);
    rd(8'h21, 8'h00);
    host_i.wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    // Temperature profile table over enable, back-off and cool bits
    tv = 8'($urandom_range(255, 20));
    cc = 8'($urandom_range(255, 0));
    term_voltage_setting <= tv;
    fast_charge_current_setting <= cc;
    zone_cool_pin <= 1'b1;
    for (k = 0; k < 8; k++) begin
      cfg = {k[2], k[1], k[0], 1'b1, 1'($urandom), 3'h5};
      host_i.wr(8'h1F, cfg);
      rd(8'h1F, cfg);
      tick(4);
      check(term_voltage_target, (k[2] & k[0]) ? tv - (k[1] ? 8'h0F : 8'h0A) : tv);
      check(fast_charge_current_target, cc);
    end
    zone_cool_pin <= 1'b0;
    zone_warm_pin <= 1'b1;
    host_i.wr(8'h1F, 8'h90);
    tick(6);
    check(fast_charge_current_target, cc >> 1);
    check(term_voltage_target, tv);
    host_i.wr(8'h1F, 8'h10);
    tick(6);
    check(fast_charge_current_target, cc);
    // Junction setpoint codes and the flag just above and at each setpoint
    for (k = 0; k < 8; k++) begin
      host_i.wr(8'h1F, 8'(k));
      junction_temp_degc <= 8'(87 + 6 * k);
      tick(3);
      check(junction_setpoint_degc, 8'(86 + 6 * k));
      check(thermal_regulation_flag, 1'b1);
      junction_temp_degc <= 8'(86 + 6 * k);
      tick(3);
      check(thermal_regulation_flag, 1'b0);
    end
    // Overcurrent with protection off, then short debounce without charger
    host_i.wr(8'h20, 8'h20);
    tick(2);
    check(overcurrent_monitor_continuous, 1'b1);
    check(overcurrent_threshold, 4'h0);
    overcurrent_pin <= 1'b1;
    tick(1200);
    check(battery_switch_on, 1'b1);
    check(8'(irq_cnt), 8'h00);
    host_i.wr(8'h20, 8'h01);
    tick(1000);
    check(battery_switch_on, 1'b1);
    check(8'(irq_cnt), 8'h01);
    wait_sw(1'b0, 100);
    check(buck_enable, 1'b0);
    overcurrent_pin <= 1'b0;
    tick(300);
    check(battery_switch_on, 1'b0);
    charger_valid_pin <= 1'b1;
    wait_sw(1'b1, 20);
    // Alarm-only trip keeps the switch closed
    host_i.wr(8'h20, 8'h41);
    overcurrent_pin <= 1'b1;
    tick(1200);
    check(8'(irq_cnt), 8'h02);
    check(battery_switch_on, 1'b1);
    overcurrent_pin <= 1'b0;
    charger_valid_pin <= 1'b0;
    tick(10);
    // Long debounce with recycling and no charger
    host_i.wr(8'h20, 8'h91);
    overcurrent_pin <= 1'b1;
    wait_sw(1'b0, 70);
    overcurrent_pin <= 1'b0;
    tick(90);
    check(battery_switch_on, 1'b0);
    wait_sw(1'b1, 40);
    // Watchdog expiry with full and charger-only scope
    host_i.wr(8'h21, 8'h80);
    pulse_wd();
    check(charger_enable, 1'b0);
    tick(90);
    check(battery_switch_on, 1'b0);
    wait_sw(1'b1, 30);
    host_i.wr(8'h21, 8'h20);
    tick(1);
    check(buck_enable, 1'b0);
    host_i.wr(8'h21, 8'h00);
    wait_sw(1'b1, 120);
    pulse_wd();
    check(charger_enable, 1'b0);
    check(battery_switch_on, 1'b1);
    // Mode requests while the disconnect input is high
    battery_disconnect_input <= 1'b1;
    tick(6);
    mode(4'h9);
    check(operating_mode, 4'h0);
    host_i.wr(8'h21, 8'h4E);
    rd(8'h21, 8'h4A);
    mode(4'h3);
    check(operating_mode, 4'h0);
    mode(4'h9);
    check(operating_mode, 4'h9);
    tick(10);
    finish_test();
  end
endmodule
